// [hsps_consts.svh]
`ifndef HSPS_CONSTS_SVH
`define HSPS_CONSTS_SVH

// Reset timeout and clock rate
`define HSPS_CLK_HZ          125000000
`define HSPS_TIMEOUT_US      200
`define HSPS_TIMEOUT_CYC     ((`HSPS_TIMEOUT_US * (`HSPS_CLK_HZ / 1000000)))
`define HSPS_TMR_W           32

// Width of the synchronised pin bundle
`define HSPS_PIN_W           12

// Supply select encodings
`define HSPS_SEL_BOTH        2'h0
`define HSPS_SEL_5V          2'h1
`define HSPS_SEL_3V          2'h2

// Comparator inputs: bit 0 is 5V, bit 1 is 3.3V
`define HSPS_BIT_5V          0
`define HSPS_BIT_3V          1

`endif

// [hsps_pkg.sv]
package hsps_pkg;

    typedef enum logic [2:0] {
        HSPS_OFF      = 3'b000,
        HSPS_SEATED   = 3'b001,
        HSPS_RAMP     = 3'b010,
        HSPS_CARD_OK  = 3'b011,
        HSPS_READY    = 3'b100
    } hsps_state_t;

    typedef enum logic [1:0] {
        HSPS_DL_IDLE  = 2'b00,
        HSPS_DL_ARMED = 2'b01,
        HSPS_DL_RUN   = 2'b10,
        HSPS_DL_SPENT = 2'b11
    } hsps_dl_t;

endpackage

// [hsps_sync.sv]
`timescale 1ns/1ns
`default_nettype none

module hsps_sync
#(
    parameter int W = 1
)
(
    // Clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rst,
    // Data
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } hsps_sync_st_t;

    hsps_sync_st_t st_reg;
    hsps_sync_st_t st_next;

    always_comb
    begin
        st_next        = st_reg;
        st_next.meta   = async_in;
        st_next.stable = st_reg.meta;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign sync_out = st_reg.stable;

endmodule

`default_nettype wire

// [hsps_seq.sv]
// Behaviour
// - Static high enable permits one download
// - Download waits for timeout then select high
// - Select drop ends download mode
// - Power-down shorts both gates off fast
// - Power-on gives inactive outputs, gates off
// - Low power permit inhibits power-up outputs
// - Power permit loss drops power, restarting reset/timer
// - Host reset low holds resets asserted
// - Host reset release starts timer, holds reset
// - Supply select picks 5V, 3V or both
// - Good supplies plus permit release gates
// - Driver enable asserts with gate release
// - Card supplies good start timer, voltage good
// - Timeout releases resets, asserts card ready
// - Host supply loss resets and drivers off
// - Card supply loss asserts resets
// - Arm download on held rising enable edge
// - Armed plus select: zero bit, data from zero
`timescale 1ns/1ns
`default_nettype none
`include "hsps_consts.svh"

module hsps_seq
    import hsps_pkg::*;
#(
    parameter int TIMEOUT_CYC = `HSPS_TIMEOUT_CYC
)
(
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // Host side pins
    input  wire logic       host_power_permit,
    input  wire logic       host_reset_in_n,
    input  wire logic [1:0] supply_select,
    input  wire logic [1:0] host_supply_good,
    input  wire logic       seat_detect_a_n,
    input  wire logic       seat_detect_b_n,
    // Card side monitors
    input  wire logic [1:0] card_supply_good,
    // Download control pins
    input  wire logic       download_enable_pin,
    input  wire logic       chip_select,
    // Power control outputs
    output logic            gate_drive_low_rail,
    output logic            gate_drive_high_rail,
    output logic            high_side_driver_enable_n,
    output logic            card_voltage_good,
    output logic            card_ready_n,
    output logic            card_reset_n,
    output logic            card_reset,
    // Download status
    output logic            download_active,
    output logic            download_lead_zero,
    output logic            download_addr_clear
);

    typedef struct packed {
        hsps_state_t           state;
        logic [`HSPS_TMR_W-1:0] tmr;
        logic                  in_reset;
        hsps_dl_t              dl;
        logic                  dd_prev;
        logic                  lead;
        logic                  gate_on;
        logic                  vgood;
        logic                  ready;
    } hsps_st_t;

    hsps_st_t st_reg;
    hsps_st_t st_next;

    logic [`HSPS_PIN_W-1:0] raw_in;
    logic [`HSPS_PIN_W-1:0] syn;
    logic                   permit;
    logic                   hrst_n;
    logic [1:0]             sel;
    logic [1:0]             hgood;
    logic [1:0]             seat_n;
    logic                   seated;
    logic [1:0]             cgood;
    logic                   dd;
    logic                   cs;
    logic                   host_ok;
    logic                   card_ok;

    // Every pin is asynchronous to clk_sys; one bundle keeps equal latency
    assign raw_in = {chip_select, host_power_permit, host_reset_in_n, supply_select,
                     host_supply_good, seat_detect_a_n, seat_detect_b_n, card_supply_good,
                     download_enable_pin};

    hsps_sync #(.W(`HSPS_PIN_W)) u_sync_pins
    (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .async_in (raw_in),
        .sync_out (syn)
    );

    assign {cs, permit, hrst_n, sel, hgood, seat_n, cgood, dd} = syn;
    assign seated = ~|seat_n;

    // Qualify only the selected rails; the spare select code means both
    assign host_ok = (sel == `HSPS_SEL_5V) ? hgood[`HSPS_BIT_5V]
                   : (sel == `HSPS_SEL_3V) ? hgood[`HSPS_BIT_3V] : &hgood;
    assign card_ok = (sel == `HSPS_SEL_5V) ? cgood[`HSPS_BIT_5V]
                   : (sel == `HSPS_SEL_3V) ? cgood[`HSPS_BIT_3V] : &cgood;

    always_comb
    begin
        st_next         = st_reg;
        st_next.dd_prev = dd;

        // Power path; permit gates progress, and its loss also restarts the reset timer
        case (st_reg.state)
            HSPS_OFF:
            begin
                if (seated)
                begin
                    st_next.state = HSPS_SEATED;
                end
            end
            HSPS_SEATED:
            begin
                if (host_ok && permit)
                begin
                    st_next.state = HSPS_RAMP;
                end
            end
            HSPS_RAMP, HSPS_CARD_OK, HSPS_READY:
            begin
                if (card_ok && st_reg.state == HSPS_RAMP)
                begin
                    st_next.state = HSPS_CARD_OK;
                end
            end
            default:
            begin
                st_next.state = HSPS_OFF;
            end
        endcase

        // Loss of seating, permit or host rail drops power at once
        if (st_reg.state != HSPS_OFF && st_reg.state != HSPS_SEATED
            && (!host_ok || !permit || !seated))
        begin
            st_next.state = seated ? HSPS_SEATED : HSPS_OFF;
        end
        else if (st_reg.state != HSPS_OFF && !seated)
        begin
            st_next.state = HSPS_OFF;
        end
        else if ((st_reg.state == HSPS_CARD_OK || st_reg.state == HSPS_READY) && !card_ok)
        begin
            st_next.state = HSPS_RAMP;
        end

        st_next.gate_on = (st_next.state == HSPS_RAMP || st_next.state == HSPS_CARD_OK
                           || st_next.state == HSPS_READY);
        st_next.vgood   = (st_next.state == HSPS_CARD_OK || st_next.state == HSPS_READY);

        // Reset timer; any reset cause restarts the count
        if (!hrst_n || !st_next.vgood)
        begin
            st_next.in_reset = 1'b1;
            st_next.tmr      = '0;
        end
        else if (st_reg.in_reset)
        begin
            if (st_reg.tmr >= `HSPS_TMR_W'(TIMEOUT_CYC - 1))
            begin
                st_next.in_reset = 1'b0;
            end
            else
            begin
                st_next.tmr = st_reg.tmr + `HSPS_TMR_W'(1);
            end
        end
        st_next.ready = !st_next.in_reset && st_next.vgood;

        // Download arming, once per rising edge; the run starts only outside reset
        st_next.lead = 1'b0;
        case (st_reg.dl)
            HSPS_DL_IDLE:
            begin
                if (dd && !st_reg.dd_prev)
                begin
                    st_next.dl = HSPS_DL_ARMED;
                end
            end
            HSPS_DL_ARMED:
            begin
                if (!dd)
                begin
                    st_next.dl = HSPS_DL_IDLE;
                end
                else if (cs && !st_reg.in_reset)
                begin
                    st_next.dl   = HSPS_DL_RUN;
                    st_next.lead = 1'b1;
                end
            end
            HSPS_DL_RUN:
            begin
                if (!cs)
                begin
                    st_next.dl = HSPS_DL_SPENT;
                end
            end
            HSPS_DL_SPENT:
            begin
                if (!dd)
                begin
                    st_next.dl = HSPS_DL_IDLE;
                end
            end
            default:
            begin
                st_next.dl = HSPS_DL_IDLE;
            end
        endcase
    end

    // Pin high out of reset counts as a rising edge (dd_prev clears)
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            st_reg          <= '0;
            st_reg.state    <= HSPS_OFF;
            st_reg.dl       <= HSPS_DL_IDLE;
            st_reg.in_reset <= 1'b1;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign gate_drive_low_rail       = st_reg.gate_on;
    assign gate_drive_high_rail      = st_reg.gate_on;
    assign high_side_driver_enable_n = ~st_reg.gate_on;
    assign card_voltage_good         = st_reg.vgood;
    assign card_ready_n              = ~st_reg.ready;
    assign card_reset                = st_reg.in_reset;
    assign card_reset_n              = ~st_reg.in_reset;
    assign download_active           = (st_reg.dl == HSPS_DL_RUN);
    assign download_lead_zero        = st_reg.lead;
    assign download_addr_clear       = st_reg.lead;

    chk_reset_pair: assert property (@(posedge clk_sys) disable iff (rst)
        card_reset != card_reset_n)
        else $error("Reset outputs not complementary");
    chk_gate_drv: assert property (@(posedge clk_sys) disable iff (rst)
        gate_drive_low_rail == ~high_side_driver_enable_n)
        else $error("Driver enable not with gates");
    chk_host_rst: assert property (@(posedge clk_sys) disable iff (rst)
        !host_reset_in_n [*3] |=> card_reset)
        else $error("Host reset did not hold reset");
    chk_permit_off: assert property (@(posedge clk_sys) disable iff (rst)
        !host_power_permit [*4] |-> !gate_drive_high_rail)
        else $error("Gates on without permit");
    chk_ready_rst: assert property (@(posedge clk_sys) disable iff (rst)
        !card_ready_n |-> !card_reset && card_voltage_good)
        else $error("Ready while in reset");
    chk_seat_gate: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(gate_drive_low_rail) |-> seated)
        else $error("Gates on while unseated");
    chk_dl_exit: assert property (@(posedge clk_sys) disable iff (rst)
        download_active && !cs |=> !download_active)
        else $error("Download not left on deselect");
    chk_dl_start: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(download_active) |-> $past(!st_reg.in_reset) && download_lead_zero)
        else $error("Download began during reset");
    chk_rst_release: assert property (@(posedge clk_sys) disable iff (rst)
        $fell(card_reset) |-> $past(st_reg.tmr) >= `HSPS_TMR_W'(TIMEOUT_CYC - 1))
        else $error("Reset released early");

    cov_ready: cover property (@(posedge clk_sys) $fell(card_ready_n));
    cov_dl: cover property (@(posedge clk_sys) $fell(download_active));
    cov_drop: cover property (@(posedge clk_sys) $fell(gate_drive_low_rail));

endmodule

`default_nettype wire

// [hsps_card_model.sv]
`timescale 1ns/1ns
`default_nettype none

module hsps_card_model
#(
    parameter int RAMP_CYC = 5
)
(
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // Gate drive and injected fault
    input  wire logic       gate_on,
    input  wire logic       rail_fault,
    // Card rail monitors
    output logic [1:0]      card_supply_good
);
    int ramp_cnt;

    // Shorted gates collapse the rails at once, no ramp down
    always_ff @(posedge clk_sys)
    begin
        if (rst || !gate_on)
            ramp_cnt <= 0;
        else if (ramp_cnt < RAMP_CYC)
            ramp_cnt <= ramp_cnt + 1;
    end

    assign card_supply_good = (ramp_cnt == RAMP_CYC && !rail_fault) ? 2'h3 : 2'h0;
endmodule
`default_nettype wire

// [hot_swap_power_sequencer_tb.sv]
`timescale 1ns/1ns
`default_nettype none

module hot_swap_power_sequencer_tb;
    localparam int TO = 20;
    // Row: sel, host good, permit, seat_n, expected gate
    localparam logic [7:0] ROWS [12] = '{8'h39, 8'h18, 8'h59, 8'h68, 8'hA9, 8'h98,
                                         8'hF9, 8'hE8, 8'h39, 8'h30, 8'h3A, 8'h3C};
    logic       clk_sys    = 1'b0;
    logic       rst        = 1'b1;
    logic       permit     = 1'b0;
    logic       hrst_n     = 1'b1;
    logic [1:0] sel        = 2'h0;
    logic [1:0] hsg        = 2'h0;
    logic [1:0] seat_n     = 2'h3;
    logic       dd         = 1'b0;
    logic       cs         = 1'b0;
    logic       fault      = 1'b0;
    logic       pulse_seen = 1'b0;
    logic       gl, gh, den_n, vgood, rdy_n, crst_n, crst, dact, lz, ac;
    logic [1:0] card_good;
    int         n_mismatch = 0;
    int         n_compared = 0;
    int         n;

    hsps_seq #(.TIMEOUT_CYC(TO)) u_hsps_seq (
        .clk_sys(clk_sys), .rst(rst), .host_power_permit(permit),
        .host_reset_in_n(hrst_n), .supply_select(sel), .host_supply_good(hsg),
        .seat_detect_a_n(seat_n[0]), .seat_detect_b_n(seat_n[1]),
        .card_supply_good(card_good), .download_enable_pin(dd), .chip_select(cs),
        .gate_drive_low_rail(gl), .gate_drive_high_rail(gh),
        .high_side_driver_enable_n(den_n), .card_voltage_good(vgood),
        .card_ready_n(rdy_n), .card_reset_n(crst_n), .card_reset(crst),
        .download_active(dact), .download_lead_zero(lz), .download_addr_clear(ac));

    hsps_card_model u_hsps_card_model (
        .clk_sys(clk_sys), .rst(rst), .gate_on(gl & gh), .rail_fault(fault),
        .card_supply_good(card_good));

    initial
    begin
        forever #4 clk_sys = ~clk_sys;
    end

    task automatic chk_bit(input logic got, input logic exp);
        n_compared++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_vec(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic get(input int w);
        case (w)
            0: get = gl;
            1: get = vgood;
            2: get = crst;
            default: get = dact;
        endcase
    endfunction

    task automatic tally_and_finish();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Bounded wait; a stuck output ends the run
    task automatic wait_for(input int w, input logic v, output int cnt);
        cnt = 0;
        while (get(w) !== v)
        begin
            @(negedge clk_sys);
            pulse_seen |= lz & ac;
            cnt++;
            if (cnt > 200)
            begin
                n_mismatch++;
                $display("unexpected at %0t: got %h expected %h", $time, get(w), v);
                tally_and_finish();
            end
        end
    endtask

    task automatic hold(input int w, input logic v, input int k);
        repeat (k)
        begin
            @(negedge clk_sys);
            pulse_seen |= lz & ac;
            chk_bit(get(w), v);
        end
    endtask

    initial
    begin
        repeat (4) @(negedge clk_sys);
        chk_vec({gl, gh, den_n, vgood, rdy_n, crst, crst_n, dact}, 8'h2C);
        rst = 1'b0;
        $display("test reset done");
        foreach (ROWS[i])
        begin
            {sel, hsg, permit, seat_n} = ROWS[i][7:1];
            repeat (8) @(negedge clk_sys);
            chk_bit(gl, ROWS[i][0]);
            chk_bit(gh, ROWS[i][0]);
            chk_bit(den_n, ~ROWS[i][0]);
        end
        $display("test rows done");
        hrst_n = 1'b0;
        {sel, hsg, permit, seat_n} = 7'h1C;
        wait_for(1, 1'b1, n);
        dd = 1'b1;
        cs = 1'b1;
        hold(2, 1'b1, 30);
        chk_bit(dact, 1'b0);
        chk_bit(rdy_n, 1'b1);
        cs = 1'b0;
        dd = 1'b0;
        hrst_n = 1'b1;
        wait_for(2, 1'b0, n);
        chk_bit(n >= TO && n <= TO + 6, 1'b1);
        chk_bit(rdy_n, 1'b0);
        chk_bit(crst_n, 1'b1);
        $display("test timer done");
        // Enable follows reset release, so its new rising edge arms the download
        dd = 1'b1;
        repeat (4) @(negedge clk_sys);
        pulse_seen = 1'b0;
        cs = 1'b1;
        wait_for(3, 1'b1, n);
        hold(3, 1'b1, 2);
        chk_bit(pulse_seen, 1'b1);
        cs = 1'b0;
        wait_for(3, 1'b0, n);
        chk_bit(n <= 5, 1'b1);
        cs = 1'b1;
        hold(3, 1'b0, 10);
        cs = 1'b0;
        $display("test download done");
        fault = 1'b1;
        wait_for(2, 1'b1, n);
        chk_bit(n <= 6, 1'b1);
        fault = 1'b0;
        wait_for(2, 1'b0, n);
        chk_bit(n >= TO, 1'b1);
        $display("test card loss done");
        // Mid-run reset; enable still high must count as a fresh edge
        rst = 1'b1;
        repeat (2) @(negedge clk_sys);
        chk_vec({gl, gh, den_n, vgood, rdy_n, crst, crst_n, dact}, 8'h2C);
        rst = 1'b0;
        pulse_seen = 1'b0;
        cs = 1'b1;
        wait_for(3, 1'b1, n);
        chk_bit(n >= TO, 1'b1);
        chk_bit(crst, 1'b0);
        chk_bit(pulse_seen, 1'b1);
        cs = 1'b0;
        wait_for(3, 1'b0, n);
        $display("test mid-run reset done");
        hsg = 2'h1;
        wait_for(0, 1'b0, n);
        chk_bit(n <= 6, 1'b1);
        chk_bit(gh, 1'b0);
        chk_bit(crst, 1'b1);
        chk_bit(den_n, 1'b1);
        $display("test host loss done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
